// ==== atc_top.v ====
// Purpose: Start, reference and pause trigger control for an acquisition engine.
// Assumes: One clock hclk at 250 MHz; sample_tick comes from same-clock logic.
// Notes: Registers are reached over AHB-Lite with zero wait states.
//
// What this block does
// - Start source: terminal, bus line 0..6, internal.
// - Digital start fires on configured edge.
// - Analog start fires on first rising edge.
// - Start terminal output pulses with start.
// - Start terminal is input after reset.
// - Without reference, store only post-start samples.
// - Start trigger also begins pre-trigger capture.
// - Ignore reference until pre count captured.
// - Full buffer overwrites oldest while waiting.
// - After reference, capture post count then stop.
// - Reference uses same sources, configured edge.
// - Analog reference on first rising edge.
// - Reference terminal output pulses with reference.
// - Reference terminal is input after reset.
// - Pause suspends sampling; never routed out.
// - Digital pause acts at configured level.
// - Analog pause gates sample clock by level.
// - Pause responds to level, not edges.
// - Finite mode stops after configured samples.
// - Software command starts without hardware start.
//
// The address map and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "atc_defines.vh"
module atc_top (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    input wire [7:0] pft_in,
    output reg start_trigger_terminal_out,
    output reg start_trigger_terminal_oe_n,
    output reg reference_trigger_terminal_out,
    output reg reference_trigger_terminal_oe_n,
    input wire [6:0] bus_line_in,
    input wire [3:0] internal_in,
    input wire analog_event,
    input wire sample_tick,
    output reg sample_wr,
    output reg sample_discard,
    output reg acq_running,
    output reg acq_done
);
    // Acquisition states.
    localparam [2:0] S_IDLE = 3'd0;
    localparam [2:0] S_WAIT = 3'd1;
    localparam [2:0] S_PRE = 3'd2;
    localparam [2:0] S_ARMED = 3'd3;
    localparam [2:0] S_POST = 3'd4;
    localparam [2:0] S_RUN = 3'd5;

    // Synchronised pins: analog event, bus lines, terminals.
    wire [15:0] pin_sync;
    // Every selectable source in code order.
    wire [19:0] src_vec;

    // Control, source selection and count registers.
    reg [`ATC_C_W-1:0] ctrl;
    reg [`ATC_SRC_W-1:0] start_src;
    reg [`ATC_SRC_W-1:0] ref_src;
    reg [`ATC_SRC_W-1:0] pause_src;
    reg [`ATC_CW-1:0] buf_size;
    reg [`ATC_CW-1:0] pre_count;

    // Bus data-phase bookkeeping.
    reg wr_pend;
    reg [7:0] wr_addr;
    reg start_cmd;
    reg stop_cmd;

    // Engine state and counters.
    reg [2:0] state;
    reg [`ATC_CW-1:0] fill_cnt;
    reg [`ATC_CW-1:0] seq_cnt;
    reg trig_seen;
    reg start_prev;
    reg ref_prev;
    reg [2:0] next_state;

    // Combinational trigger decode.
    wire start_lvl;
    wire ref_lvl;
    wire pause_lvl;
    wire start_fire;
    wire ref_fire;
    wire paused;
    wire take;
    wire buf_full;
    wire [`ATC_CW-1:0] post_count;
    wire addr_ok;

    // Pins from outside the clock domain pass two flip-flops first.
    atc_sync #(.W(16)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in({analog_event, bus_line_in, pft_in}),
        .sync_out(pin_sync)
    );

    // Internal signals share the clock and need no synchroniser.
    assign src_vec = {pin_sync[15], internal_in, pin_sync[14:0]};

    // Picks the level of one source; unknown codes read low.
    function src_val;
        input [`ATC_SRC_W-1:0] code;
        input [19:0] vec;
        begin
            if (code <= `ATC_SRC_LAST) begin
                src_val = vec[code];
            end else begin
                src_val = 1'b0;
            end
        end
    endfunction

    assign start_lvl = src_val(start_src, src_vec);
    assign ref_lvl = src_val(ref_src, src_vec);
    assign pause_lvl = src_val(pause_src, src_vec);

    // Analog sources always trigger on the rising edge, whatever the edge bit.
    assign start_fire = (start_src == `ATC_SRC_ANALOG || !ctrl[`ATC_C_ST_FALL]) ?
        (start_lvl && !start_prev) : (!start_lvl && start_prev);
    assign ref_fire = (ref_src == `ATC_SRC_ANALOG || !ctrl[`ATC_C_RF_FALL]) ?
        (ref_lvl && !ref_prev) : (!ref_lvl && ref_prev);

    // Pause compares a level only, so an edge alone never stalls a sample.
    assign paused = ctrl[`ATC_C_PS_EN] &&
        (pause_lvl == ctrl[`ATC_C_PS_HIGH]);

    // A sample is taken on a tick in any capturing state while not paused.
    assign take = sample_tick && !paused && (state == S_PRE ||
        state == S_ARMED || state == S_POST || state == S_RUN);

    assign buf_full = (fill_cnt >= buf_size);
    assign post_count = buf_size - pre_count;

    // Only word-aligned accesses are decoded; hsize is not checked.
    assign addr_ok = (haddr[1:0] == 2'b00);

    // Bus slave: address phase decode and registered read data.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend <= 1'b0;
            if (hsel && htrans[1] && hready) begin
                wr_pend <= hwrite && addr_ok;
                wr_addr <= haddr[7:0];
                hrdata <= 32'h00000000;
                if (!hwrite && addr_ok) begin
                    // Unmapped reads return zero with an OKAY answer.
                    case (haddr[7:0])
                        `ATC_A_CTRL: hrdata <= {22'h0, ctrl};
                        `ATC_A_SRC: hrdata <= {11'h0, pause_src, 3'h0,
                            ref_src, 3'h0, start_src};
                        `ATC_A_SIZE: hrdata <= {16'h0000, buf_size};
                        `ATC_A_PRE: hrdata <= {16'h0000, pre_count};
                        `ATC_A_STAT: hrdata <= {26'h0, paused, buf_full,
                            acq_done, trig_seen, (state == S_ARMED),
                            acq_running};
                        `ATC_A_CNT: hrdata <= {16'h0000, fill_cnt};
                        default: hrdata <= 32'h00000000;
                    endcase
                end
            end
        end
    end

    // Register writes land in the data phase using the latched address.
    // Start and stop are command bits: they pulse once and read as zero.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= `ATC_CTRL_RST;
            start_src <= `ATC_SRC_RST;
            ref_src <= `ATC_SRC_RST;
            pause_src <= `ATC_SRC_RST;
            buf_size <= `ATC_CNT_RST;
            pre_count <= `ATC_CNT_RST;
            start_cmd <= 1'b0;
            stop_cmd <= 1'b0;
        end else begin
            start_cmd <= 1'b0;
            stop_cmd <= 1'b0;
            if (wr_pend) begin
                case (wr_addr)
                    `ATC_A_CTRL: begin
                        ctrl <= hwdata[`ATC_C_W-1:0];
                        ctrl[`ATC_C_START] <= 1'b0;
                        ctrl[`ATC_C_STOP] <= 1'b0;
                        start_cmd <= hwdata[`ATC_C_START];
                        stop_cmd <= hwdata[`ATC_C_STOP];
                    end
                    `ATC_A_SRC: begin
                        start_src <= hwdata[`ATC_S_START +: `ATC_SRC_W];
                        ref_src <= hwdata[`ATC_S_REF +: `ATC_SRC_W];
                        pause_src <= hwdata[`ATC_S_PAUSE +: `ATC_SRC_W];
                    end
                    `ATC_A_SIZE: buf_size <= hwdata[`ATC_CW-1:0];
                    `ATC_A_PRE: pre_count <= hwdata[`ATC_CW-1:0];
                    default: begin
                        // Writes elsewhere are accepted and dropped.
                    end
                endcase
            end
        end
    end

    // Next-state logic of the acquisition sequence.
    always @* begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (start_cmd) begin
                    // With no hardware start, the command itself starts.
                    if (start_src == `ATC_SRC_NONE) begin
                        next_state = ctrl[`ATC_C_REF_EN] ? S_PRE : S_RUN;
                    end else begin
                        next_state = S_WAIT;
                    end
                end
            end
            S_WAIT: begin
                if (start_fire) begin
                    next_state = ctrl[`ATC_C_REF_EN] ? S_PRE : S_RUN;
                end
            end
            S_PRE: begin
                // A reference edge here is ignored on purpose.
                if (take && seq_cnt + `ATC_CNT_ONE >= pre_count) begin
                    next_state = S_ARMED;
                end else if (pre_count == `ATC_CNT_RST) begin
                    next_state = S_ARMED;
                end
            end
            S_ARMED: begin
                if (ref_fire) begin
                    next_state = (post_count == `ATC_CNT_RST) ? S_IDLE : S_POST;
                end
            end
            S_POST: begin
                if (take && seq_cnt + `ATC_CNT_ONE >= post_count) begin
                    next_state = S_IDLE;
                end
            end
            S_RUN: begin
                if (ctrl[`ATC_C_FINITE] && take &&
                    seq_cnt + `ATC_CNT_ONE >= buf_size) begin
                    next_state = S_IDLE;
                end
            end
            default: next_state = S_IDLE;
        endcase
        // Software stop ends any acquisition at once.
        if (stop_cmd && state != S_IDLE) begin
            next_state = S_IDLE;
        end
    end

    // State, counters and edge history.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= S_IDLE;
            fill_cnt <= `ATC_CNT_RST;
            seq_cnt <= `ATC_CNT_RST;
            trig_seen <= 1'b0;
            start_prev <= 1'b0;
            ref_prev <= 1'b0;
            acq_done <= 1'b0;
        end else begin
            state <= next_state;
            start_prev <= start_lvl;
            ref_prev <= ref_lvl;
            // The sequence counter restarts at every phase change.
            if (next_state != state) begin
                seq_cnt <= `ATC_CNT_RST;
            end else if (take) begin
                seq_cnt <= seq_cnt + `ATC_CNT_ONE;
            end
            if (state == S_IDLE && next_state != S_IDLE) begin
                // A new run empties the buffer and clears the old trigger flag.
                fill_cnt <= `ATC_CNT_RST;
                trig_seen <= 1'b0;
            end else if (take && !buf_full) begin
                // Fill stops at the size; the full buffer then wraps.
                fill_cnt <= fill_cnt + `ATC_CNT_ONE;
            end
            // Done stays up while waiting in S_WAIT for a start; only a real start clears it,
            // so software still sees the last result while a trigger is pending.
            if ((state == S_IDLE || state == S_WAIT) &&
                (next_state == S_PRE || next_state == S_RUN)) begin
                acq_done <= 1'b0;
            end
            if (state == S_ARMED && ref_fire) begin
                trig_seen <= 1'b1;
            end
            if (state != S_IDLE && state != S_WAIT && next_state == S_IDLE) begin
                acq_done <= 1'b1;
            end
        end
    end

    // Sample strobes and run flag toward the host buffer.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sample_wr <= 1'b0;
            sample_discard <= 1'b0;
            acq_running <= 1'b0;
        end else begin
            // Only samples after the start are ever written.
            sample_wr <= take;
            // Writing into a full buffer drops its oldest sample.
            sample_discard <= take && buf_full;
            acq_running <= (next_state != S_IDLE && next_state != S_WAIT);
        end
    end

    // Trigger terminals: outputs follow the internal triggers, not their source.
    // Output enables are active low and stay high (input) until enabled.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_trigger_terminal_out <= 1'b0;
            start_trigger_terminal_oe_n <= 1'b1;
            reference_trigger_terminal_out <= 1'b0;
            reference_trigger_terminal_oe_n <= 1'b1;
        end else begin
            start_trigger_terminal_oe_n <= !ctrl[`ATC_C_ST_OUT];
            reference_trigger_terminal_oe_n <= !ctrl[`ATC_C_RF_OUT];
            // One-cycle active-high pulses; software starts pulse too.
            start_trigger_terminal_out <= (state == S_IDLE || state == S_WAIT) &&
                (next_state == S_PRE || next_state == S_RUN);
            reference_trigger_terminal_out <= (state == S_ARMED) && ref_fire;
            // No pause output exists anywhere in this block.
        end
    end
endmodule // atc_top
`default_nettype wire

// ==== atc_defines.vh ====
// Purpose: Shared constants for the acquisition trigger control block.
// Assumes: Included by bare name by the top module and the bench.
// Notes: Offsets are byte addresses on the AHB-Lite register bus.
`ifndef ATC_DEFINES_VH
`define ATC_DEFINES_VH

// Register byte offsets, compared against haddr[7:0].
`define ATC_A_CTRL 8'h00
`define ATC_A_SRC 8'h04
`define ATC_A_SIZE 8'h08
`define ATC_A_PRE 8'h0C
`define ATC_A_STAT 8'h10
`define ATC_A_CNT 8'h14

// Control register bit positions.
`define ATC_C_START 0
`define ATC_C_STOP 1
`define ATC_C_FINITE 2
`define ATC_C_REF_EN 3
`define ATC_C_ST_OUT 4
`define ATC_C_RF_OUT 5
`define ATC_C_ST_FALL 6
`define ATC_C_RF_FALL 7
`define ATC_C_PS_EN 8
`define ATC_C_PS_HIGH 9
`define ATC_C_W 10
`define ATC_CTRL_RST 10'h000

// Source register field positions, each field five bits wide.
`define ATC_S_START 0
`define ATC_S_REF 8
`define ATC_S_PAUSE 16
`define ATC_SRC_W 5
`define ATC_SRC_RST 5'h1F

// Source codes: 0..7 terminals, 8..14 bus lines, 15..18 internal, 19 analog.
`define ATC_SRC_ANALOG 5'h13
`define ATC_SRC_LAST 5'h13
`define ATC_SRC_NONE 5'h1F

// Counter width and reset value of the size and pre-trigger registers.
`define ATC_CW 16
`define ATC_CNT_RST 16'h0000
`define ATC_CNT_ONE 16'h0001

// Status bit positions.
`define ATC_ST_RUN 0
`define ATC_ST_ARMED 1
`define ATC_ST_TRIG 2
`define ATC_ST_DONE 3
`define ATC_ST_FULL 4
`define ATC_ST_PAUSE 5

`endif

// ==== atc_sync.v ====
// Purpose: Two-stage synchroniser for a vector of asynchronous inputs.
// Assumes: Each bit is an independent level; no bus coherence is needed.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module atc_sync #(
    parameter W = 1
) (
    input wire hclk,
    input wire hresetn,
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);
    // First stage, read by the second stage only.
    reg [W-1:0] meta;

    // Both stages clear to zero so no stale level survives reset.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule // atc_sync
`default_nettype wire

// ==== atc_properties.sv ====
// Purpose: Port-level properties of the acquisition trigger control block.
// Assumes: One clock hclk and an asynchronous active-low hresetn.
// Notes: Watches design outputs and the sample_tick input; bound to atc_top at the foot.
`timescale 1ns/1ps
`default_nettype none
module atc_properties (
    input wire hclk,
    input wire hresetn,
    input wire hreadyout,
    input wire hresp,
    input wire sample_tick,
    input wire start_trigger_terminal_out,
    input wire reference_trigger_terminal_out,
    input wire sample_wr,
    input wire sample_discard,
    input wire acq_running,
    input wire acq_done
);
    // Everything lives in one domain, so clock and reset are given once.
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // The slave never inserts wait states and always answers OKAY.
    a_bus_zero_wait: assert property (hreadyout && !hresp)
        else $error("bus slave stalled or answered with an error");
    a_start_pulse_one: assert property (start_trigger_terminal_out |=> !start_trigger_terminal_out)
        else $error("start terminal pulse longer than one cycle");
    a_ref_pulse_one: assert property (reference_trigger_terminal_out |=> !reference_trigger_terminal_out)
        else $error("reference terminal pulse longer than one cycle");
    a_start_then_run: assert property (start_trigger_terminal_out |-> acq_running)
        else $error("start pulse without a running acquisition");
    // The reference pulse rises on the same edge as its state change, which may end the run; the check looks two edges back.
    a_ref_while_run: assert property (reference_trigger_terminal_out |-> $past(acq_running, 2))
        else $error("reference pulse outside a running acquisition");
    a_discard_pair: assert property (sample_discard |-> sample_wr)
        else $error("discard without a sample write");
    a_wr_from_tick: assert property (sample_wr |-> $past(sample_tick) && $past(acq_running))
        else $error("sample write without an accepted tick");
    a_done_idle: assert property ($rose(acq_done) |-> !acq_running)
        else $error("done raised while still running");
    a_done_sticky: assert property ($fell(acq_done) |-> ##[0:2] acq_running)
        else $error("done cleared without a new start");
endmodule // atc_properties

bind atc_top atc_properties u_props (
    .hclk(hclk),
    .hresetn(hresetn),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .sample_tick(sample_tick),
    .start_trigger_terminal_out(start_trigger_terminal_out),
    .reference_trigger_terminal_out(reference_trigger_terminal_out),
    .sample_wr(sample_wr),
    .sample_discard(sample_discard),
    .acq_running(acq_running),
    .acq_done(acq_done)
);
`default_nettype wire

// ==== atc_partner.sv ====
// Purpose: Host-side partner: sample clock source and buffer write counter.
// Assumes: Same clock as the block; the bench gates ticks with tick_en.
// Notes: Ticks come every fourth cycle, slow enough to stop them cleanly.
`timescale 1ns/1ps
`default_nettype none
module atc_partner (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic tick_en,
    input wire logic sample_wr,
    input wire logic sample_discard,
    output var logic sample_tick,
    output var logic [15:0] wr_count,
    output var logic [15:0] disc_count
);
    logic [1:0] phase; // Free-running tick divider.

    // Tick generation and counting of what the block hands to the buffer.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase <= 2'h0;
            sample_tick <= 1'b0;
            wr_count <= 16'h0000;
            disc_count <= 16'h0000;
        end else begin
            phase <= phase + 2'h1;
            sample_tick <= tick_en && (phase == 2'h3);
            if (sample_wr) wr_count <= wr_count + 16'h0001;
            if (sample_discard) disc_count <= disc_count + 16'h0001;
        end
    end
endmodule // atc_partner
`default_nettype wire

// ==== atc_tb.sv ====
// Purpose: Self-checking bench for the acquisition trigger control block.
// Assumes: Zero-wait AHB-Lite slave; trigger pins need a few cycles to count.
// Notes: Scenarios cover software, hardware, reference and pause control.
`timescale 1ns/1ps
`default_nettype none
`include "atc_defines.vh"
module testbench;
    logic hclk, hresetn, hsel, hwrite, analog_event, tick_en;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] pft_in;
    logic [6:0] bus_line_in;
    logic [3:0] internal_in;
    wire hreadyout, hresp, st_out, st_oe_n, rf_out, rf_oe_n;
    wire sample_tick, sample_wr, sample_discard, acq_running, acq_done;
    wire [31:0] hrdata;
    wire [15:0] wr_count, disc_count;
    logic [15:0] w0, d0;
    int error_cnt = 0, check_count = 0, cyc = 0, st_n = 0, rf_n = 0, s0, r0, n, i;
    // Hardware start sources: terminal 0, bus line 6, internal 1, analog.
    logic [4:0] cd [0:3] = '{5'h00, 5'h0E, 5'h10, 5'h13};
    logic fl [0:3] = '{1'b0, 1'b1, 1'b0, 1'b0};
    // Pause sources: bus line 2 pausing high, analog pausing low.
    logic [4:0] pc [0:1] = '{5'h0A, 5'h13};
    logic ph [0:1] = '{1'b1, 1'b0};

    atc_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pft_in(pft_in), .start_trigger_terminal_out(st_out),
        .start_trigger_terminal_oe_n(st_oe_n), .reference_trigger_terminal_out(rf_out),
        .reference_trigger_terminal_oe_n(rf_oe_n), .bus_line_in(bus_line_in),
        .internal_in(internal_in), .analog_event(analog_event),
        .sample_tick(sample_tick), .sample_wr(sample_wr),
        .sample_discard(sample_discard), .acq_running(acq_running), .acq_done(acq_done));

    atc_partner u_host (.hclk(hclk), .hresetn(hresetn), .tick_en(tick_en),
        .sample_wr(sample_wr), .sample_discard(sample_discard),
        .sample_tick(sample_tick), .wr_count(wr_count), .disc_count(disc_count));

    // A 4 ns clock for 250 MHz.
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    // Terminal pulse counters and the hang guard.
    always @(posedge hclk) begin
        cyc++;
        if (st_out === 1'b1) st_n++;
        if (rf_out === 1'b1) rf_n++;
        if (cyc == 20000) begin
            error_cnt++;
            test_done;
        end
    end

    task test_done;
        if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One whole-word transfer; the address phase holds until hready is seen.
    task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task wt(input int c);
        repeat (c) @(posedge hclk);
    endtask

    // Drives the level of whichever source a code selects.
    task set_src(input logic [4:0] c, input logic v);
        @(posedge hclk);
        if (c < 5'h08) pft_in[c[2:0]] <= v;
        else if (c < 5'h0F) bus_line_in[c - 5'h08] <= v;
        else if (c < 5'h13) internal_in[c - 5'h0F] <= v;
        else analog_event <= v;
    endtask

    // Bounded wait for a run to start and then to finish.
    task run_wait;
        n = 0;
        while (acq_running !== 1'b1 && n < 100) begin @(posedge hclk); n++; end
        while (acq_done !== 1'b1 && n < 400) begin @(posedge hclk); n++; end
        wt(3);
    endtask

    initial begin
        hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 32'h0; hwdata = 32'h0;
        htrans = 2'b00; hsize = 3'b010; pft_in = 8'h00; bus_line_in = 7'h00;
        internal_in = 4'h0; analog_event = 1'b0; tick_en = 1'b1;
        wt(10);
        hresetn <= 1'b1;
        wt(3);
        chk("start_oe_n", st_oe_n, 1);
        chk("ref_oe_n", rf_oe_n, 1);
        for (i = 0; i < 6; i++) begin
            ahb(0, i * 4, 0);
            chk("reset_reg", rd, (i == 1) ? 32'h001F1F1F : (i == 4) ? 32'h10 : 32'h0);
        end
        ahb(1, 32'h18, 32'hFFFFFFFF);
        ahb(0, 32'h18, 0);
        chk("unmapped", rd, 0);
        // Software start, finite run of two samples.
        ahb(1, `ATC_A_SIZE, 2);
        w0 = wr_count;
        ahb(1, `ATC_A_CTRL, 32'h5);
        run_wait;
        chk("sw_samples", wr_count - w0, 2);
        ahb(0, `ATC_A_STAT, 0);
        chk("stat_done", rd[3], 1);
        // Hardware start on each kind of source, with the terminal driven out.
        for (i = 0; i < 4; i++) begin
            set_src(cd[i], fl[i]);
            wt(4);
            ahb(1, `ATC_A_SIZE, 1);
            ahb(1, `ATC_A_SRC, {11'h000, 5'h1F, 3'h0, 5'h1F, 3'h0, cd[i]});
            ahb(1, `ATC_A_CTRL, {25'h0, fl[i], 6'h15});
            wt(10);
            chk("no_early_start", acq_running, 0);
            s0 = st_n;
            w0 = wr_count;
            set_src(cd[i], !fl[i]);
            run_wait;
            chk("start_pulse", st_n - s0, 1);
            chk("start_oe_n_drive", st_oe_n, 0);
            chk("hw_samples", wr_count - w0, 1);
            set_src(cd[i], fl[i]);
        end
        // Pre-trigger run: buffer 4, pre count 2, reference on terminal 1.
        ahb(1, `ATC_A_SIZE, 4);
        ahb(1, `ATC_A_PRE, 2);
        ahb(1, `ATC_A_SRC, 32'h001F011F);
        tick_en <= 1'b0;
        ahb(1, `ATC_A_CTRL, 32'h2D);
        wt(6);
        r0 = rf_n;
        set_src(5'h01, 1'b1);
        wt(8);
        set_src(5'h01, 1'b0);
        wt(4);
        chk("early_ref", rf_n - r0, 0);
        w0 = wr_count;
        d0 = disc_count;
        tick_en <= 1'b1;
        n = 0;
        while (wr_count - w0 < 6 && n < 200) begin @(posedge hclk); n++; end
        tick_en <= 1'b0;
        wt(4);
        chk("wrap_discard", disc_count - d0, 2);
        ahb(0, `ATC_A_STAT, 0);
        chk("armed", rd[1], 1);
        w0 = wr_count;
        set_src(5'h01, 1'b1);
        n = 0;
        while (rf_n == r0 && n < 50) begin @(posedge hclk); n++; end
        chk("ref_pulse", rf_n - r0, 1);
        chk("ref_oe_n_drive", rf_oe_n, 0);
        tick_en <= 1'b1;
        n = 0;
        while (acq_done !== 1'b1 && n < 200) begin @(posedge hclk); n++; end
        wt(3);
        chk("post_samples", wr_count - w0, 2);
        set_src(5'h01, 1'b0);
        // Continuous runs gated by a pause level, digital and analog.
        for (i = 0; i < 2; i++) begin
            set_src(pc[i], ph[i]);
            ahb(1, `ATC_A_SRC, {11'h000, pc[i], 16'h1F1F});
            ahb(1, `ATC_A_CTRL, {22'h0, ph[i], 9'h101});
            w0 = wr_count;
            wt(40);
            chk("paused", wr_count - w0, 0);
            ahb(0, `ATC_A_STAT, 0);
            chk("stat_pause", rd[5], 1);
            set_src(pc[i], !ph[i]);
            wt(40);
            chk("resumed", (wr_count - w0) != 0, 1);
            ahb(1, `ATC_A_CTRL, 32'h2);
            wt(4);
            chk("stopped", acq_running, 0);
        end
        test_done;
    end
endmodule // testbench
`default_nettype wire
